// ==== verilog/spi_frame_pkg.sv ====
// constants and types for the angle frame serial port
package spi_frame_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int IDLE_MAX_NS = 10000;
  localparam int IDLE_CYC = (IDLE_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MTO_MIN_NS = 135000;
  localparam int MTO_MAX_NS = 145000;
  // aim at the middle of the window so clock tolerance keeps us inside it
  localparam int MTO_CYC = ((MTO_MIN_NS + MTO_MAX_NS) / 2) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam int FRAME_BITS = 48;
  localparam int BIT_CNT_W = 6;
  localparam int ANGLE_W = 22;
  localparam int PAD_W = 15;
  localparam int CRC_W = 7;
  localparam int CRC_BODY_W = 26;
  localparam int CRC_DATA_W = 32;
  localparam logic [CRC_W-1:0] CRC_POLY = 7'h5b;
  localparam logic [CRC_W-1:0] CRC_INIT = 7'h00;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_FRAME_LO = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_FRAME_HI = 12'h00c;
  localparam int RES_W = 5;
  localparam logic [RES_W-1:0] RES_MAX = 5'h16;
  localparam int CNT16_W = 16;

  typedef struct packed {
    logic [PAD_W-1:0] zero_pad_bits;
    logic factory_zero_flag;
    logic position_valid_flag;
    logic frame_synced_flag;
    logic [ANGLE_W-1:0] angle_value;
    logic repeat_result_flag;
    logic [CRC_W-1:0] crc;
  } frame_t;

  typedef struct packed {
    logic position_valid_flag;
    logic frame_synced_flag;
    logic [ANGLE_W-1:0] angle_value;
  } result_t;

  // enable in bit 0, resolution in bits 12:8, to match the reset word below
  typedef struct packed {
    logic [CNT16_W-1:0] unused;
    logic [2:0] pad;
    logic [RES_W-1:0] resolution;
    logic [6:0] pad2;
    logic enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 32'h0000_1601;

  typedef struct packed {
    logic [CNT16_W-1:0] frame_count;
    logic [12:0] pad;
    logic in_progress;
    logic stale;
    logic valid;
  } status_t;
endpackage : spi_frame_pkg

// ==== verilog/level_sync.sv ====
// two-stage synchroniser for the serial clock pin
`timescale 1ns/1ps
`default_nettype none
module level_sync (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic pin,
  output logic level
);
  logic meta_r;
  logic sync_r;

  // reset to high: the line idles high, so no false edge at release
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end
    else
    begin
      meta_r <= pin;
      sync_r <= meta_r;
    end
  end

  assign level = sync_r;
endmodule : level_sync
`default_nettype wire

// ==== verilog/crc7_calc.sv ====
// combinational crc7, msb first, no reflection, no final xor
`timescale 1ns/1ps
`default_nettype none
module crc7_calc #(
  parameter int W = spi_frame_pkg::CRC_DATA_W
) (
  input wire logic [W-1:0] data,
  output logic [spi_frame_pkg::CRC_W-1:0] crc
);
  always_comb
  begin
    logic [spi_frame_pkg::CRC_W-1:0] c;
    logic fb;
    c = spi_frame_pkg::CRC_INIT;
    fb = 1'b0;
    for (int i = W - 1; i >= 0; i--)
    begin
      fb = c[spi_frame_pkg::CRC_W-1] ^ data[i];
      c = {c[spi_frame_pkg::CRC_W-2:0], 1'b0};
      if (fb)
      begin
        c = c ^ spi_frame_pkg::CRC_POLY;
      end
    end
    crc = c;
  end
endmodule : crc7_calc
`default_nettype wire

// ==== verilog/spi_angle_frame_tx.sv ====
// serial angle frame transmitter with measurement trigger and apb registers
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spi_angle_frame_tx (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SCLK,
  output logic DATA,
  output logic MEAS_TRIG,
  input wire logic MEAS_BUSY,
  input wire logic MEAS_DONE,
  input wire logic MEAS_VALID,
  input wire logic [spi_frame_pkg::ANGLE_W-1:0] MEAS_ANGLE,
  input wire logic ZERO_DEFAULT,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [spi_frame_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  logic sclk_s;
  logic sclk_d_r;
  logic rise;
  logic fall;
  logic load;
  logic idle_rst;
  logic in_progress;
  logic [spi_frame_pkg::BIT_CNT_W-1:0] bit_cnt_r;
  logic [spi_frame_pkg::FRAME_BITS-1:0] shift_r;
  logic [spi_frame_pkg::CNT_W-1:0] idle_cnt_r;
  logic [spi_frame_pkg::CNT_W-1:0] mto_cnt_r;
  logic mto_hit;
  logic trig_r;
  logic trig_src_r;
  logic pend_r;
  spi_frame_pkg::result_t latest_r;
  logic stale_r;
  spi_frame_pkg::ctrl_t ctrl_r;
  spi_frame_pkg::ctrl_t wctrl_w;
  logic [spi_frame_pkg::CNT16_W-1:0] frame_cnt_r;
  spi_frame_pkg::frame_t frame_w;
  logic [spi_frame_pkg::CRC_W-1:0] crc_w;
  logic [spi_frame_pkg::CRC_W-1:0] resid_w;
  logic apb_access;
  logic [31:0] rdata_nxt;
  logic err_nxt;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic [spi_frame_pkg::CNT_W-1:0] trig_gap_r;

  function automatic logic [spi_frame_pkg::ANGLE_W-1:0] res_mask(
    input logic [spi_frame_pkg::RES_W-1:0] res
  );
    logic [spi_frame_pkg::RES_W-1:0] r;
    r = (res > spi_frame_pkg::RES_MAX) ? spi_frame_pkg::RES_MAX : res;
    res_mask = ~({spi_frame_pkg::ANGLE_W{1'b1}} << r);
  endfunction : res_mask

  // only edges of the controller clock move the frame; nothing here drives it
  level_sync u_sclk_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .pin(SCLK),
    .level(sclk_s)
  );

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      sclk_d_r <= 1'b1;
    else
      sclk_d_r <= sclk_s;
  end

  assign rise = ~sclk_d_r & sclk_s;
  assign fall = sclk_d_r & ~sclk_s;
  assign load = fall && bit_cnt_r == '0 && ctrl_r.enable;
  assign in_progress = MEAS_BUSY | pend_r;
  assign mto_hit = mto_cnt_r == spi_frame_pkg::CNT_W'(spi_frame_pkg::MTO_CYC - 1);

  // idle is counted while the line rests high; disabling holds the port in reset
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      idle_cnt_r <= '0;
    else if (rise || fall || !sclk_s)
      idle_cnt_r <= '0;
    else if (!idle_rst)
      idle_cnt_r <= idle_cnt_r + 1'b1;
  end

  // a fall ends the idle at once, so the edge that wakes the port also loads the frame
  assign idle_rst = (idle_cnt_r == spi_frame_pkg::CNT_W'(spi_frame_pkg::IDLE_CYC - 1) && !fall)
    || !ctrl_r.enable;

  always_comb
  begin
    frame_w = '0;
    frame_w.zero_pad_bits = '0;
    frame_w.factory_zero_flag = ZERO_DEFAULT;
    frame_w.position_valid_flag = latest_r.position_valid_flag;
    frame_w.frame_synced_flag = latest_r.frame_synced_flag;
    // angle is passed even when invalid; receivers must ignore it then
    frame_w.angle_value = latest_r.angle_value & res_mask(ctrl_r.resolution);
    frame_w.repeat_result_flag = stale_r;
  end

  crc7_calc #(.W(spi_frame_pkg::CRC_DATA_W)) u_crc (
    .data(spi_frame_pkg::CRC_DATA_W'(frame_w[spi_frame_pkg::CRC_W +: spi_frame_pkg::CRC_BODY_W])),
    .crc(crc_w)
  );

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      bit_cnt_r <= '0;
    else if (idle_rst)
      bit_cnt_r <= '0;
    else if (fall)
      bit_cnt_r <= (bit_cnt_r == spi_frame_pkg::BIT_CNT_W'(spi_frame_pkg::FRAME_BITS - 1))
        ? '0 : bit_cnt_r + 1'b1;
  end

  // bit 47 is always zero, so the line already shows it before the first fall
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      shift_r <= '0;
    else if (idle_rst)
      shift_r <= '0;
    else if (load)
      // crc joins here, not in frame_w, so the crc input never loops back on itself
      shift_r <= {frame_w[spi_frame_pkg::FRAME_BITS-1:spi_frame_pkg::CRC_W], crc_w};
    else if (rise)
      shift_r <= {shift_r[spi_frame_pkg::FRAME_BITS-2:0], 1'b0};
  end

  assign DATA = shift_r[spi_frame_pkg::FRAME_BITS-1];

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      trig_r <= 1'b0;
    else
      trig_r <= ((load && !in_progress) || mto_hit) && !trig_r;
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      trig_src_r <= 1'b0;
    else if (load && !in_progress && !trig_r)
      trig_src_r <= 1'b1;
    else if (mto_hit && !trig_r)
      trig_src_r <= 1'b0;
  end

  // covers the latency between our trigger and the engine raising busy
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      pend_r <= 1'b0;
    else if (trig_r)
      pend_r <= 1'b1;
    else if (MEAS_DONE)
      pend_r <= 1'b0;
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      mto_cnt_r <= '0;
    else if (trig_r)
      mto_cnt_r <= '0;
    else if (!mto_hit)
      mto_cnt_r <= mto_cnt_r + 1'b1;
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      latest_r <= '0;
    else if (MEAS_DONE)
    begin
      latest_r.position_valid_flag <= MEAS_VALID;
      latest_r.frame_synced_flag <= trig_src_r;
      latest_r.angle_value <= MEAS_ANGLE;
    end
  end

  // a fresh result wins over the frame that marks the old one as sent
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      stale_r <= 1'b0;
    else if (MEAS_DONE)
      stale_r <= 1'b0;
    else if (load)
      stale_r <= 1'b1;
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      frame_cnt_r <= '0;
    else if (load)
      frame_cnt_r <= frame_cnt_r + 1'b1;
  end

  assign MEAS_TRIG = trig_r;

  // apb: ready one cycle into the access phase; write lands on the ready edge
  assign apb_access = PSEL && PENABLE;
  assign wctrl_w = PWDATA;

  always_comb
  begin
    rdata_nxt = '0;
    err_nxt = 1'b0;
    case (PADDR)
      spi_frame_pkg::ADDR_CTRL:
        rdata_nxt = ctrl_r;
      spi_frame_pkg::ADDR_STATUS:
        rdata_nxt = spi_frame_pkg::status_t'({frame_cnt_r, 13'h0000, in_progress,
          stale_r, latest_r.position_valid_flag});
      spi_frame_pkg::ADDR_FRAME_LO:
        rdata_nxt = shift_r[31:0];
      spi_frame_pkg::ADDR_FRAME_HI:
        rdata_nxt = {16'h0000, shift_r[spi_frame_pkg::FRAME_BITS-1:32]};
      default:
        err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= apb_access && !pready_r;
      prdata_r <= (apb_access && !pready_r && !PWRITE) ? rdata_nxt : '0;
      pslverr_r <= apb_access && !pready_r && err_nxt;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      ctrl_r <= spi_frame_pkg::CTRL_RESET;
    else if (apb_access && pready_r && PWRITE && PADDR == spi_frame_pkg::ADDR_CTRL)
    begin
      ctrl_r.enable <= wctrl_w.enable;
      ctrl_r.resolution <= wctrl_w.resolution;
    end
  end

  assign PREADY = pready_r;
  assign PRDATA = prdata_r;
  assign PSLVERR = pslverr_r;

  // residue check: crc over body plus sent crc must come out zero
  crc7_calc #(.W(spi_frame_pkg::CRC_BODY_W + spi_frame_pkg::CRC_W)) u_crc_chk (
    .data(shift_r[0 +: spi_frame_pkg::CRC_BODY_W + spi_frame_pkg::CRC_W]),
    .crc(resid_w)
  );

  property p_pad_zero;
    @(posedge CLK) disable iff (SYS_RST)
    load |=> shift_r[spi_frame_pkg::FRAME_BITS-1 -: spi_frame_pkg::PAD_W] == '0;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("pad bits not zero");

  property p_capture;
    @(posedge CLK) disable iff (SYS_RST)
    load |=> shift_r[32] == $past(ZERO_DEFAULT) && shift_r[31] == $past(latest_r[23]);
  endproperty
  a_capture: assert property (p_capture) else $error("flags not captured");

  property p_crc_resid;
    @(posedge CLK) disable iff (SYS_RST)
    load |=> resid_w == '0;
  endproperty
  a_crc_resid: assert property (p_crc_resid) else $error("frame crc wrong");

  property p_shift_rise;
    @(posedge CLK) disable iff (SYS_RST)
    rise && !load && !idle_rst |=> DATA == $past(shift_r[spi_frame_pkg::FRAME_BITS-2]);
  endproperty
  a_shift_rise: assert property (p_shift_rise) else $error("no shift on rise");

  property p_hold;
    @(posedge CLK) disable iff (SYS_RST)
    !rise && !idle_rst |=> $stable(DATA);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved without rise");

  property p_idle;
    @(posedge CLK) disable iff (SYS_RST)
    idle_rst |=> bit_cnt_r == '0 && DATA == 1'b0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle did not reset port");

  property p_trig;
    @(posedge CLK) disable iff (SYS_RST)
    load && !in_progress && !trig_r |=> MEAS_TRIG ##1 !MEAS_TRIG;
  endproperty
  a_trig: assert property (p_trig) else $error("frame did not trigger");

  property p_no_retrig;
    @(posedge CLK) disable iff (SYS_RST)
    $rose(MEAS_TRIG) |-> !$past(in_progress) || $past(mto_hit);
  endproperty
  a_no_retrig: assert property (p_no_retrig) else $error("retrigger while busy");

  // cycles since the last trigger, saturating; keeps the timeout check free of long ranges
  always_ff @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      trig_gap_r <= '0;
    else if (MEAS_TRIG)
      trig_gap_r <= '0;
    else if (trig_gap_r != '1)
      trig_gap_r <= trig_gap_r + 1'b1;
  end

  property p_timeout;
    @(posedge CLK) disable iff (SYS_RST)
    trig_gap_r < spi_frame_pkg::CNT_W'(spi_frame_pkg::MTO_MAX_NS / spi_frame_pkg::CLK_PERIOD_NS);
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout trigger missing");

  property p_stale;
    @(posedge CLK) disable iff (SYS_RST)
    MEAS_DONE |=> !stale_r;
  endproperty
  a_stale: assert property (p_stale) else $error("new result marked stale");

  property p_len;
    @(posedge CLK) disable iff (SYS_RST)
    bit_cnt_r < spi_frame_pkg::BIT_CNT_W'(spi_frame_pkg::FRAME_BITS);
  endproperty
  a_len: assert property (p_len) else $error("frame longer than 48 bits");

  c_frame: cover property (@(posedge CLK) disable iff (SYS_RST) load ##1 rise);
  c_idle: cover property (@(posedge CLK) disable iff (SYS_RST) idle_rst && bit_cnt_r != '0);
  c_mto: cover property (@(posedge CLK) disable iff (SYS_RST) mto_hit && !trig_r);
  c_race: cover property (@(posedge CLK) disable iff (SYS_RST) MEAS_DONE && load);
endmodule : spi_angle_frame_tx
`default_nettype wire

// ==== tb/spi_ctrl_model.sv ====
// controller model: makes the serial clock and collects frames
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [5:0] len,
  input wire logic miso,
  output logic sclk,
  output logic [47:0] frame,
  output logic done
);
  logic run = 1'b0;
  logic smp = 1'b0;
  int ph = 0;
  int nb = 0;
  initial sclk = 1'b1;
  initial done = 1'b0;
  initial frame = 48'h000000000000;
  // half period of 4 clk gives the 400 ns link clock
  always @(posedge clk)
  begin
    done <= 1'b0;
    smp <= 1'b0;
    // taken one cycle after the fall: the port only sees the fall three cycles later
    if (smp)
      frame <= {frame[46:0], miso};
    if (go && !run)
    begin
      run <= 1'b1;
      ph <= 0;
      nb <= 0;
    end
    else if (run)
    begin
      ph <= (ph == 3) ? 0 : ph + 1;
      if (ph == 3 && sclk)
      begin
        sclk <= 1'b0;
        smp <= 1'b1;
      end
      else if (ph == 3)
      begin
        sclk <= 1'b1;
        nb <= nb + 1;
        if (nb + 1 == int'(len))
        begin
          run <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : spi_ctrl_model
`default_nettype wire

// ==== tb/spi_angle_frame_tx_bench.sv ====
// self-checking bench for the angle frame serial port
`timescale 1ns/1ps
`default_nettype none
module spi_angle_frame_tx_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclk, data, done, meas_trig, pready, pslverr, err;
  logic go = 1'b0;
  logic [5:0] len = 6'h30;
  logic [47:0] frame, rxf;
  logic meas_busy = 1'b0, meas_done = 1'b0, meas_valid = 1'b0, zero_def = 1'b0;
  logic [21:0] meas_angle = 22'h000000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  int fail_count = 0, samples_checked = 0, trig_count = 0, cyc = 0, last_trig = 0, gap = 0;
  int mdly = 0;
  localparam logic [47:0] ALL = 48'hffffffffffff;
  always #25 clk = ~clk;

  spi_angle_frame_tx u_dut (.CLK(clk), .SYS_RST(sys_rst), .SCLK(sclk), .DATA(data),
    .MEAS_TRIG(meas_trig), .MEAS_BUSY(meas_busy), .MEAS_DONE(meas_done),
    .MEAS_VALID(meas_valid), .MEAS_ANGLE(meas_angle), .ZERO_DEFAULT(zero_def),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  spi_ctrl_model u_ctrl (.clk(clk), .go(go), .len(len), .miso(data), .sclk(sclk),
    .frame(frame), .done(done));

  function automatic logic [21:0] angle_of(input int n);
    return 22'h2c5a3 ^ (22'(n) * 22'h01357);
  endfunction : angle_of

  // measurement engine stand-in; the second trigger is made slow to leave it busy
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    meas_done <= 1'b0;
    if (meas_trig === 1'b1)
    begin
      meas_busy <= 1'b1;
      mdly <= (trig_count == 1) ? 1500 : 40;
      gap <= cyc - last_trig;
      last_trig <= cyc;
      trig_count <= trig_count + 1;
    end
    else if (mdly > 0)
    begin
      mdly <= mdly - 1;
      if (mdly == 1)
      begin
        meas_busy <= 1'b0;
        meas_done <= 1'b1;
        meas_valid <= (trig_count != 4);
        meas_angle <= angle_of(trig_count - 1);
      end
    end
  end

  function automatic logic [47:0] mkf(input logic z, v, s, input logic [21:0] a,
    input logic st);
    logic [31:0] body;
    logic [6:0] c;
    body = {6'h00, z, v, s, a, st};
    c = 7'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((c[6] ^ body[i]) ? 7'h5b : 7'h00);
    return {15'h0000, body[25:0], c};
  endfunction : mkf

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic hang;
    fail_count++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    test_done;
  endtask : hang

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // request held until the rising edge that samples pready high; data taken there
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rx(input logic [5:0] l, input logic [47:0] exp, input logic [47:0] m);
    int n;
    @(posedge clk);
    len <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 1000 && done !== 1'b1; n++)
      @(negedge clk);
    if (n == 1000)
      hang();
    rxf = frame;
    if (l == 6'h30)
    begin
      chk(rxf & m, exp & m);
      chk(rxf, mkf(rxf[32], rxf[31], rxf[30], rxf[29:8], rxf[7]));
    end
  endtask : rx

  initial
  begin
    int n;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h00000000);
    chk(48'(rd), 48'(spi_frame_pkg::CTRL_RESET));
    apb(1'b1, 12'h010, 32'hffffffff);
    chk(48'(err), 48'h1);
    apb(1'b0, 12'h010, 32'h00000000);
    chk(48'({err, rd}), 48'h100000000);
    $display("test registers done");
    zero_def <= 1'b1;
    rx(6'h0a, ALL, ALL);
    // idle longer than the 200-cycle limit drops the 10-bit partial frame
    repeat (220) @(posedge clk);
    rx(6'h30, mkf(1'b1, 1'b1, 1'b1, angle_of(0), 1'b0), ALL);
    rx(6'h30, mkf(1'b1, 1'b1, 1'b1, angle_of(0), 1'b1), ALL);
    chk(48'(trig_count), 48'h2);
    // three frames loaded, result sent, measurement still running, result valid
    apb(1'b0, 12'h004, 32'h00000000);
    chk(48'(rd), 48'h000000030007);
    $display("test frames done");
    for (n = 0; n < 3000 && trig_count < 3; n++)
      @(negedge clk);
    if (n == 3000)
      hang();
    chk(48'(gap >= 2700 && gap <= 2900), 48'h1);
    zero_def <= 1'b0;
    apb(1'b1, 12'h000, 32'h00001001);
    repeat (60) @(posedge clk);
    rx(6'h30, mkf(1'b0, 1'b1, 1'b0, angle_of(2) & 22'h00ffff, 1'b0), ALL);
    repeat (60) @(posedge clk);
    // angle and crc follow the undefined angle; the crc is still checked inside rx
    rx(6'h30, mkf(1'b0, 1'b0, 1'b1, 22'h000000, 1'b0), 48'hffffc0000080);
    $display("test timeout and resolution done");
    apb(1'b1, 12'h000, 32'h00001600);
    rx(6'h30, 48'h000000000000, ALL);
    chk(48'(trig_count), 48'h5);
    $display("test disable done");
    test_done;
  end
endmodule : spi_angle_frame_tx_bench
`default_nettype wire
